/* File: rtl/rif_flags.sv */
// status flag block of an FSK/OOK radio with AXI4-Lite register access
// assumes event inputs on aclk; battery comparator output is asynchronous
// How it works
// - mode ready sets on mode reached, clears on change
// - receiver ready after receive chain settles
// - transmitter ready after amplifier ramp in transmit
// - lock flag follows synthesizer lock in active modes
// - strength flag sets over threshold, clears leave/w1c
// - timeout sets on event, clears leave/empty
// - preamble flag cleared only by writing one
// - sync flag clears leave/empty, w1c only continuous
// - full flag high exactly at 66 bytes
// - empty flag high while buffer holds nothing
// - level flag high when count exceeds threshold
// - overrun sets except sleep; w1c flushes buffer
// - packet sent in transmit, clears leaving transmit
// - payload ready after last byte, crc gated
// - crc pass sets on good crc, clears empty
// - battery low cleared only by writing one
// - battery compare only when enabled; trim default 010
//
// Added by the designer: the AXI4-Lite register port.
module rif_flags
    import rif_pkg::*;
#(
    parameter logic [6:0] BUF_DEPTH = 7'd66
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire rif_pkg::rif_mode_t mode,
    input wire rif_pkg::rif_evt_t evt,
    input wire logic [7:0] measured_strength,
    input wire logic [6:0] buffer_count,
    input wire logic battery_below,
    output logic [2:0] battery_threshold_trim,
    output logic battery_detect_enable,
    output logic buffer_flush,
    output logic irq
);
    import rif_pkg::*;

    rif_state_t state;
    rif_state_t next_state;
    logic battery_below_sync;

    // ------------------------------------------------------------------
    // battery comparator crossing
    // ------------------------------------------------------------------
    rif_sync2 #(.WIDTH(1)) u_bat_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(battery_below),
        .sync_out(battery_below_sync)
    );

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    logic do_write;
    logic do_read;
    logic [31:0] wmask;
    logic [31:0] wbits;
    logic [31:0] rd;
    logic rd_ok;
    logic wr_ok;
    logic [7:0] w1c1;
    logic [7:0] w1c2;
    logic mode_changed;
    logic in_rx;
    logic in_tx;
    logic leave_rx;
    logic leave_tx;
    logic is_empty;
    logic empty_edge;
    logic reached;
    logic payload_ok;
    logic [15:0] rises;

    always_comb begin
        next_state = state;
        do_write = state.aw_held && state.w_held && !state.bvalid;
        do_read = s_axi_arvalid && state.arready;
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{state.wstrb[i]}};
        end
        wbits = state.wdata & wmask;
        w1c1 = 8'h00;
        w1c2 = 8'h00;
        wr_ok = 1'b1;
        // write decode; flag writes only reach the clearable bits
        if (do_write) begin
            case (state.aw_addr)
                `RIF_ADDR_FLAGS1: begin
                    w1c1[`RIF_B_STRENGTH] = wbits[`RIF_B_STRENGTH];
                    w1c1[`RIF_B_PREAMBLE] = wbits[`RIF_B_PREAMBLE];
                    // only continuous mode lets software clear sync
                    w1c1[`RIF_B_SYNC] = wbits[`RIF_B_SYNC] && state.cfg[`RIF_CFG_CONT];
                end
                `RIF_ADDR_FLAGS2: begin
                    w1c2[`RIF_B_OVERRUN] = wbits[`RIF_B_OVERRUN];
                    w1c2[`RIF_B_BATTERY] = wbits[`RIF_B_BATTERY];
                end
                `RIF_ADDR_CONFIG: begin
                    next_state.cfg = (state.cfg & ~wmask[`RIF_CFG_W-1:0])
                        | wbits[`RIF_CFG_W-1:0];
                end
                `RIF_ADDR_IRQ_STATUS: begin
                    next_state.sts = state.sts & ~wbits[15:0];
                end
                `RIF_ADDR_IRQ_MASK: begin
                    next_state.msk = (state.msk & ~wmask[15:0]) | wbits[15:0];
                end
                default: begin
                    wr_ok = 1'b0;
                end
            endcase
        end

        // mode tracking
        mode_changed = mode != state.mode_prev;
        in_rx = mode == rif_receive;
        in_tx = mode == rif_transmit;
        leave_rx = state.mode_prev == rif_receive && !in_rx;
        leave_tx = state.mode_prev == rif_transmit && !in_tx;
        is_empty = buffer_count == 7'd0;
        empty_edge = is_empty && !state.empty_prev;
        next_state.mode_prev = mode;
        next_state.empty_prev = is_empty;

        // readiness of the requested mode
        case (mode)
            rif_sleep: reached = 1'b1;
            rif_standby: reached = evt.osc_running;
            rif_synthesizer_mode: reached = evt.synth_locked;
            rif_receive: reached = evt.rx_sampling;
            rif_transmit: reached = evt.pa_ramp_done;
            default: reached = 1'b0;
        endcase
        // a change restarts the wait, reaching is judged next cycle
        next_state.f1[`RIF_B_MODE_READY] = !mode_changed
            && (state.f1[`RIF_B_MODE_READY] || reached);
        next_state.f1[`RIF_B_RX_READY] = in_rx
            && (state.f1[`RIF_B_RX_READY] || evt.rx_chain_done);
        next_state.f1[`RIF_B_TX_READY] = in_tx
            && (state.f1[`RIF_B_TX_READY] || evt.pa_ramp_done);
        next_state.f1[`RIF_B_LOCK] = evt.synth_locked
            && (in_rx || in_tx || mode == rif_synthesizer_mode);
        // set beats a software clear in the same cycle
        next_state.f1[`RIF_B_STRENGTH] =
            (in_rx && measured_strength > state.cfg[`RIF_CFG_STRENGTH])
            || (state.f1[`RIF_B_STRENGTH] && in_rx && !w1c1[`RIF_B_STRENGTH]);
        next_state.f1[`RIF_B_TIMEOUT] = evt.timeout
            || (state.f1[`RIF_B_TIMEOUT] && !leave_rx && !empty_edge);
        next_state.f1[`RIF_B_PREAMBLE] = evt.preamble
            || (state.f1[`RIF_B_PREAMBLE] && !w1c1[`RIF_B_PREAMBLE]);
        next_state.f1[`RIF_B_SYNC] = evt.sync_match
            || (state.f1[`RIF_B_SYNC] && !leave_rx && !empty_edge
            && !w1c1[`RIF_B_SYNC]);

        // buffer levels follow the count directly
        next_state.f2[`RIF_B_FULL] = buffer_count == BUF_DEPTH;
        next_state.f2[`RIF_B_EMPTY] = is_empty;
        next_state.f2[`RIF_B_LEVEL] = buffer_count > state.cfg[`RIF_CFG_BUF_THR];
        next_state.f2[`RIF_B_OVERRUN] = (evt.overrun && mode != rif_sleep)
            || (state.f2[`RIF_B_OVERRUN] && !w1c2[`RIF_B_OVERRUN]);
        next_state.flush = w1c2[`RIF_B_OVERRUN];
        next_state.f2[`RIF_B_SENT] = in_tx
            && (state.f2[`RIF_B_SENT] || evt.packet_done);
        payload_ok = !state.cfg[`RIF_CFG_CRC_ON] || state.cfg[`RIF_CFG_CRC_ACD]
            || (evt.crc_done && evt.crc_good);
        next_state.f2[`RIF_B_PAYLOAD] = (in_rx && evt.last_byte && payload_ok)
            || (state.f2[`RIF_B_PAYLOAD] && !is_empty);
        next_state.f2[`RIF_B_CRC] = (in_rx && evt.crc_done && evt.crc_good)
            || (state.f2[`RIF_B_CRC] && !empty_edge);
        // comparator only counts while the detector is on
        next_state.f2[`RIF_B_BATTERY] =
            (battery_below_sync && state.cfg[`RIF_CFG_BAT_EN])
            || (state.f2[`RIF_B_BATTERY] && !w1c2[`RIF_B_BATTERY]);

        // sticky interrupt status from flag rises, set beats clear
        rises = {next_state.f1, next_state.f2} & ~{state.f1, state.f2};
        next_state.sts = next_state.sts | rises;
        next_state.irq = |(next_state.sts & next_state.msk);

        // write channel handshakes, address and data in either order
        if (s_axi_awvalid && state.awready) begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && state.wready) begin
            next_state.w_held = 1'b1;
            next_state.wdata = s_axi_wdata;
            next_state.wstrb = s_axi_wstrb;
        end
        if (do_write) begin
            next_state.aw_held = 1'b0;
            next_state.w_held = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp = wr_ok ? `RIF_RESP_OKAY : `RIF_RESP_SLVERR;
        end else if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end
        next_state.awready = !next_state.aw_held;
        next_state.wready = !next_state.w_held;

        // read decode
        rd = 32'h0000_0000;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `RIF_ADDR_FLAGS1: rd[7:0] = state.f1;
            `RIF_ADDR_FLAGS2: rd[7:0] = state.f2;
            `RIF_ADDR_CONFIG: rd[`RIF_CFG_W-1:0] = state.cfg;
            `RIF_ADDR_IRQ_STATUS: rd[15:0] = state.sts;
            `RIF_ADDR_IRQ_MASK: rd[15:0] = state.msk;
            default: rd_ok = 1'b0;
        endcase
        if (do_read) begin
            next_state.rvalid = 1'b1;
            next_state.rdata = rd;
            next_state.rresp = rd_ok ? `RIF_RESP_OKAY : `RIF_RESP_SLVERR;
        end else if (state.rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end
        // one read in flight, so the address port waits for the answer
        next_state.arready = !next_state.rvalid;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
            state.mode_prev <= rif_sleep;
            state.empty_prev <= 1'b1;
            state.cfg <= `RIF_CFG_RESET;
            state.msk <= `RIF_MASK_RESET;
        end else begin
            state <= next_state;
        end
    end

    // outputs straight from the state flops
    assign s_axi_awready = state.awready;
    assign s_axi_wready = state.wready;
    assign s_axi_bvalid = state.bvalid;
    assign s_axi_bresp = state.bresp;
    assign s_axi_arready = state.arready;
    assign s_axi_rvalid = state.rvalid;
    assign s_axi_rdata = state.rdata;
    assign s_axi_rresp = state.rresp;
    assign battery_threshold_trim = state.cfg[`RIF_CFG_TRIM];
    assign battery_detect_enable = state.cfg[`RIF_CFG_BAT_EN];
    assign buffer_flush = state.flush;
    assign irq = state.irq;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_overrun_cleared;
        state.bvalid && $past(state.aw_addr) == `RIF_ADDR_FLAGS2;
    endsequence

    a_mode_change_clears: assert property (
        mode != state.mode_prev |=> !state.f1[`RIF_B_MODE_READY])
        else $error("mode ready survived a mode change");
    a_rx_ready_mode: assert property (
        state.f1[`RIF_B_RX_READY] |-> $past(mode) == rif_receive)
        else $error("receiver ready outside receive");
    a_tx_ready_mode: assert property (
        state.f1[`RIF_B_TX_READY] |-> $past(mode) == rif_transmit)
        else $error("transmitter ready outside transmit");
    a_lock_follow: assert property (
        evt.synth_locked && mode == rif_receive |=> state.f1[`RIF_B_LOCK])
        else $error("lock flag missed lock");
    a_preamble_sticky: assert property (
        state.f1[`RIF_B_PREAMBLE] && !do_write |=> state.f1[`RIF_B_PREAMBLE])
        else $error("preamble flag dropped without a write");
    a_full_exact: assert property (
        aresetn |=> state.f2[`RIF_B_FULL] == ($past(buffer_count) == BUF_DEPTH))
        else $error("full flag wrong");
    a_empty_exact: assert property (
        aresetn |=> state.f2[`RIF_B_EMPTY] == ($past(buffer_count) == 7'd0))
        else $error("empty flag wrong");
    a_level_exact: assert property (
        aresetn |=> state.f2[`RIF_B_LEVEL]
        == ($past(buffer_count) > $past(state.cfg[`RIF_CFG_BUF_THR])))
        else $error("level flag wrong");
    a_flush_pulse: assert property (
        state.flush |-> s_overrun_cleared ##1 !state.flush)
        else $error("flush without overrun clear");
    a_sent_tx: assert property (
        state.f2[`RIF_B_SENT] |-> $past(mode) == rif_transmit)
        else $error("packet sent outside transmit");
    a_battery_gate: assert property (
        !state.cfg[`RIF_CFG_BAT_EN] && !state.f2[`RIF_B_BATTERY]
        |=> !state.f2[`RIF_B_BATTERY])
        else $error("battery flag set while detector off");
    a_strength_leave: assert property (
        !in_rx |=> !state.f1[`RIF_B_STRENGTH])
        else $error("strength flag held outside receive");
    a_timeout_set: assert property (
        evt.timeout |=> state.f1[`RIF_B_TIMEOUT])
        else $error("timeout flag missed its event");
    a_timeout_hold: assert property (
        state.f1[`RIF_B_TIMEOUT] && !leave_rx && !empty_edge |=> state.f1[`RIF_B_TIMEOUT])
        else $error("timeout flag dropped without a hardware clear");
    a_sync_read_only: assert property (
        state.f1[`RIF_B_SYNC] && !state.cfg[`RIF_CFG_CONT] && !leave_rx && !empty_edge
        |=> state.f1[`RIF_B_SYNC])
        else $error("sync flag cleared in packet mode");
    a_overrun_sleep: assert property (
        mode == rif_sleep && !state.f2[`RIF_B_OVERRUN] |=> !state.f2[`RIF_B_OVERRUN])
        else $error("overrun flag set in sleep");
    a_payload_empty: assert property (
        is_empty && !evt.last_byte |=> !state.f2[`RIF_B_PAYLOAD])
        else $error("payload flag held with empty buffer");
    a_crc_set: assert property (
        in_rx && evt.crc_done && evt.crc_good |=> state.f2[`RIF_B_CRC])
        else $error("crc flag missed a good crc");
    a_battery_sticky: assert property (
        state.f2[`RIF_B_BATTERY] && !do_write |=> state.f2[`RIF_B_BATTERY])
        else $error("battery flag dropped without a write");
    a_irq_level: assert property (
        ##1 irq == |($past(next_state.sts) & $past(next_state.msk)))
        else $error("interrupt output wrong");
endmodule : rif_flags

/* File: rtl/rif_pkg.sv */
// types shared by the radio flag block
// assumes rif_regs.svh is on the include path
package rif_pkg;
`include "rif_regs.svh"

    // operating modes reported by the modem state machine
    typedef enum logic [2:0] {
        rif_sleep, rif_standby, rif_synthesizer_mode, rif_transmit, rif_receive
    } rif_mode_t;

    // events and levels from modem, packet engine and buffer
    typedef struct packed {
        logic osc_running;
        logic synth_locked;
        logic rx_sampling;
        logic rx_chain_done;
        logic pa_ramp_done;
        logic timeout;
        logic preamble;
        logic sync_match;
        logic overrun;
        logic packet_done;
        logic last_byte;
        logic crc_done;
        logic crc_good;
    } rif_evt_t;

    // whole state of the main module
    typedef struct packed {
        rif_mode_t mode_prev;
        logic empty_prev;
        logic [7:0] f1;
        logic [7:0] f2;
        logic [`RIF_CFG_W-1:0] cfg;
        logic [15:0] sts;
        logic [15:0] msk;
        logic aw_held;
        logic [11:0] aw_addr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic irq;
        logic flush;
    } rif_state_t;
endpackage : rif_pkg

/* File: rtl/rif_regs.svh */
// register offsets, field positions and reset values of the radio flag block
// assumes a 12-bit byte address on the register bus, 32-bit data words
`ifndef RIF_REGS_SVH
`define RIF_REGS_SVH

// ----------------------------------------------------------------------
// offsets
// ----------------------------------------------------------------------
`define RIF_IDX_FLAGS1 8'h3E
`define RIF_IDX_FLAGS2 8'h3F
`define RIF_ADDR_FLAGS1 {2'h0, `RIF_IDX_FLAGS1, 2'h0}
`define RIF_ADDR_FLAGS2 {2'h0, `RIF_IDX_FLAGS2, 2'h0}
`define RIF_ADDR_CONFIG 12'h000
`define RIF_ADDR_IRQ_STATUS 12'h004
`define RIF_ADDR_IRQ_MASK 12'h008

// ----------------------------------------------------------------------
// flag bit positions, first register then second
// ----------------------------------------------------------------------
`define RIF_B_MODE_READY 7
`define RIF_B_RX_READY 6
`define RIF_B_TX_READY 5
`define RIF_B_LOCK 4
`define RIF_B_STRENGTH 3
`define RIF_B_TIMEOUT 2
`define RIF_B_PREAMBLE 1
`define RIF_B_SYNC 0
`define RIF_B_FULL 7
`define RIF_B_EMPTY 6
`define RIF_B_LEVEL 5
`define RIF_B_OVERRUN 4
`define RIF_B_SENT 3
`define RIF_B_PAYLOAD 2
`define RIF_B_CRC 1
`define RIF_B_BATTERY 0

// ----------------------------------------------------------------------
// config register fields and reset values
// ----------------------------------------------------------------------
`define RIF_CFG_STRENGTH 7:0
`define RIF_CFG_BUF_THR 14:8
`define RIF_CFG_CRC_ON 15
`define RIF_CFG_CRC_ACD 16
`define RIF_CFG_CONT 17
`define RIF_CFG_BAT_EN 18
`define RIF_CFG_TRIM 21:19
`define RIF_CFG_W 22
`define RIF_CFG_RESET 22'h100000
`define RIF_MASK_RESET 16'h0000
`define RIF_RESP_OKAY 2'h0
`define RIF_RESP_SLVERR 2'h2

`endif

/* File: rtl/rif_sync2.sv */
// two-stage synchroniser for levels from outside the clock domain
// assumes a synchronous active-low reset on the same clock
module rif_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } rif_sync_state_t;

    rif_sync_state_t state;
    rif_sync_state_t next_state;

    // first stage feeds only the second
    always_comb begin
        next_state.meta = async_in;
        next_state.stable = state.meta;
    end

    // register both stages
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.stable;
endmodule : rif_sync2

/* File: test/rif_flags_tb_top.sv */
// self-checking bench for the radio flag block, driven over its AXI4-Lite port
// assumes rif_pkg and rif_flags compiled first, rif_regs.svh on the include path
`include "rif_regs.svh"
module rif_flags_tb_top
    import rif_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] F1 = `RIF_ADDR_FLAGS1;
    localparam logic [11:0] F2 = `RIF_ADDR_FLAGS2;
    localparam logic [11:0] CFG = `RIF_ADDR_CONFIG;
    localparam logic [11:0] STS = `RIF_ADDR_IRQ_STATUS;
    localparam logic [11:0] MSK = `RIF_ADDR_IRQ_MASK;
    localparam logic [31:0] CB = 32'h0010_0000; // trim 010 kept in every config write
    localparam logic [6:0] CNT [6] = '{7'h00, 7'h0A, 7'h0B, 7'h41, 7'h42, 7'h00};
    localparam logic [7:0] LVL [6] = '{8'h40, 8'h00, 8'h20, 8'h20, 8'hA0, 8'h40};
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, bat_below, bat_en, flush, irq;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [7:0] strength;
    logic [6:0] count;
    logic [2:0] trim;
    rif_mode_t mode;
    rif_evt_t evt;
    int n_fail, comparisons, n_flush, nf0;

    rif_flags i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .mode(mode), .evt(evt), .measured_strength(strength),
        .buffer_count(count), .battery_below(bat_below), .battery_threshold_trim(trim),
        .battery_detect_enable(bat_en), .buffer_flush(flush), .irq(irq));

    // --------------------------------------------------------------------
    // clock, flush pulse counter, watchdog
    // --------------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // counted here so a pulse of one cycle cannot slip between bus reads
    always @(posedge aclk) begin
        if (flush === 1'b1) n_flush <= n_flush + 1;
    end
    // whole run needs a few hundred cycles; a hang ends here
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        $display("watchdog expired at %0t", $time);
        report_and_stop();
    end

    // --------------------------------------------------------------------
    // bus tasks and compares
    // --------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // an edge passes first, so no strobe is assigned twice in one step
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    task automatic chk_reg(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
        rd(a);
        chk(d & 32'(m), 32'(e));
    endtask : chk_reg
    // one-cycle event pulse on top of the level inputs
    task automatic pulse(input logic [12:0] p);
        @(posedge aclk);
        evt <= evt | p;
        @(posedge aclk);
        evt <= evt & ~p;
    endtask : pulse
    task automatic settle();
        repeat (2) @(posedge aclk);
    endtask : settle
    task automatic report_and_stop();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // --------------------------------------------------------------------
    // tests
    // --------------------------------------------------------------------
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, bat_below} = '0;
        {awaddr, araddr, wdata, strength, count} = '0;
        wstrb = 4'hF;
        mode = rif_sleep;
        evt = '0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(32'(trim), 32'h2);
        chk(32'(bat_en), 32'h0);
        rd(CFG);
        chk(d & 32'h003C_0000, CB);
        rd(12'h100);
        chk({d[29:0], r}, 32'h2);
        wr(12'h100, 32'hFF);
        chk(32'(r), 32'h2);
        $display("test reset and map done");
        // mode readiness, receive chain and lock
        mode <= rif_standby;
        evt <= 13'h1000;
        // the change clears first, readiness is judged one cycle later
        settle();
        chk_reg(F1, 8'h80, 8'h80);
        mode <= rif_receive;
        evt <= 13'h1800;
        chk_reg(F1, 8'hD0, 8'h10);
        pulse(13'h0400);
        pulse(13'h0200);
        chk_reg(F1, 8'hC0, 8'hC0);
        evt <= 13'h1000;
        chk_reg(F1, 8'h10, 8'h00);
        mode <= rif_standby;
        chk_reg(F1, 8'h40, 8'h00);
        mode <= rif_transmit;
        pulse(13'h0100);
        pulse(13'h0008);
        chk_reg(F1, 8'h20, 8'h20);
        chk_reg(F2, 8'h08, 8'h08);
        mode <= rif_standby;
        chk_reg(F1, 8'h20, 8'h00);
        chk_reg(F2, 8'h08, 8'h00);
        $display("test modes done");
        // strength threshold: equal is not above
        wr(CFG, CB | 32'h40);
        mode <= rif_receive;
        strength <= 8'h40;
        chk_reg(F1, 8'h08, 8'h00);
        strength <= 8'h41;
        chk_reg(F1, 8'h08, 8'h08);
        strength <= 8'h10;
        wr(F1, 32'h08);
        chk_reg(F1, 8'h08, 8'h00);
        // detector flags and their clear paths
        pulse(13'h0040);
        pulse(13'h0080);
        pulse(13'h0020);
        chk_reg(F1, 8'h07, 8'h07);
        wr(F1, 32'h00);
        chk_reg(F1, 8'h07, 8'h07);
        wr(F1, 32'h05);
        chk_reg(F1, 8'h07, 8'h07);
        wr(CFG, CB | 32'h2_0040);
        wr(F1, 32'h01);
        chk_reg(F1, 8'h07, 8'h06);
        mode <= rif_standby;
        chk_reg(F1, 8'h07, 8'h02);
        wr(F1, 32'h02);
        chk_reg(F1, 8'h02, 8'h00);
        $display("test detectors done");
        // buffer level flags across the threshold and the full count
        wr(CFG, CB | 32'h0A00);
        for (int i = 0; i < 6; i++) begin
            count <= CNT[i];
            chk_reg(F2, 8'hE0, LVL[i]);
        end
        // payload and crc, cleared once the buffer empties
        wr(CFG, CB | 32'h8000);
        mode <= rif_receive;
        count <= 7'h05;
        pulse(13'h0006);
        chk_reg(F2, 8'h06, 8'h00);
        evt <= 13'h0001;
        pulse(13'h00A6);
        chk_reg(F2, 8'h06, 8'h06);
        count <= 7'h00;
        chk_reg(F2, 8'h06, 8'h00);
        chk_reg(F1, 8'h05, 8'h00);
        // overrun: clear by writing one flushes once; ignored in sleep
        pulse(13'h0010);
        chk_reg(F2, 8'h10, 8'h10);
        nf0 = n_flush;
        wr(F2, 32'h10);
        repeat (3) @(posedge aclk);
        chk(32'(n_flush - nf0), 32'h1);
        chk_reg(F2, 8'h10, 8'h00);
        mode <= rif_sleep;
        pulse(13'h0010);
        chk_reg(F2, 8'h10, 8'h00);
        $display("test buffer and packet done");
        // battery flag, detector enable and the interrupt path
        wr(STS, 32'hFFFF);
        wr(MSK, 32'h0001);
        bat_below <= 1'b1;
        repeat (6) @(posedge aclk);
        chk_reg(F2, 8'h01, 8'h00);
        chk(32'(irq), 32'h0);
        wr(CFG, CB | 32'h4_0000);
        settle();
        chk(32'(bat_en), 32'h1);
        chk_reg(F2, 8'h01, 8'h01);
        chk(32'(irq), 32'h1);
        bat_below <= 1'b0;
        chk_reg(F2, 8'h01, 8'h01);
        wr(F2, 32'h01);
        chk_reg(F2, 8'h01, 8'h00);
        wr(MSK, 32'h0000);
        settle();
        chk(32'(irq), 32'h0);
        wr(MSK, 32'h0001);
        settle();
        chk(32'(irq), 32'h1);
        wr(STS, 32'h0001);
        settle();
        chk(32'(irq), 32'h0);
        $display("test battery and interrupt done");
        report_and_stop();
    end
endmodule : rif_flags_tb_top
